// >>> verilog/mgmt_pkg.sv
// Purpose: Shared constants for the station-management master
// Assumes: 32-bit slave data, word addressing on the slave port
// Notes: Offsets are word indexes; byte address is four times the index
package mgmt_pkg;
  localparam int ADDR_W = 6;
  localparam logic [5:0] ACCESS_IDX = 6'h20;
  localparam logic [5:0] ADDRESSING_IDX = 6'h21;
  localparam int DEV_LSB = 0;
  localparam int PORT_LSB = 8;
  localparam int REG_LSB = 16;
  localparam logic [31:0] ADDRESSING_MASK = 32'hFFFF_1F1F;
  localparam logic [31:0] ADDRESSING_RESET = 32'h0000_0000;
  localparam int PREAMBLE_BITS = 32;
  localparam int FRAME_BITS = 64;
  localparam int DATA_FIRST_BIT = 48;
  localparam int TA_FIRST_BIT = 46;
  localparam logic [1:0] START_PAT = 2'h0;
  localparam logic [1:0] OP_ADDRESS = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ = 2'h3;
  localparam logic [1:0] TA_DRIVEN = 2'h2;
  localparam int DIVIDER_DEFAULT = 32;
  localparam int DIVIDER_MIN = 8;
  localparam int DIVIDER_MAX = 64;
  localparam real CLOCK_MHZ = 25.0;
  localparam real MGMT_MAX_MHZ = 2.5;
  localparam int DIVIDER_LEAST = int'($ceil(CLOCK_MHZ / MGMT_MAX_MHZ));
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
endpackage

// >>> verilog/frame_if.sv
// Purpose: Carries a frame request and its result between the engine and the slave
// Assumes: One frame in flight at a time
// Notes: start is a one-cycle pulse, done is a one-cycle pulse
`timescale 1ns/1ps
interface frame_if;
  logic start;
  logic [1:0] opcode;
  logic [4:0] port;
  logic [4:0] device;
  logic [15:0] payload;
  logic done;
  logic [15:0] result;
  modport ctrl (output start, output opcode, output port, output device, output payload,
    input done, input result);
  modport engine (input start, input opcode, input port, input device, input payload,
    output done, output result);
endinterface

// >>> verilog/frame_engine.sv
// Purpose: Shifts one management frame out on the clock and data pins
// Assumes: Divider even-or-odd, at least eight system clocks per bit
// Notes: Data changes on the falling management edge, is sampled on the rising one
`timescale 1ns/1ps
module frame_engine #(
  parameter int DIVIDER = mgmt_pkg::DIVIDER_DEFAULT
) (
  input wire logic clock_in,
  input wire logic arst_n_in,
  frame_if.engine fr,
  input wire logic mdio_in,
  output logic mgmt_clock_out,
  output logic mdio_out,
  output logic mdio_oe_out
);
  import mgmt_pkg::*;
  localparam int HALF = DIVIDER / 2;
  localparam logic [6:0] HALF_C = 7'(HALF);
  localparam logic [6:0] DIV_C = 7'(DIVIDER);
  logic busy;
  logic reading;
  logic [6:0] div_cnt;
  logic [6:0] bit_idx;
  logic [63:0] shifter;
  logic [15:0] capture;
  logic rise;
  logic fall;
  assign rise = busy && (div_cnt == HALF_C - 7'h01);
  assign fall = busy && (div_cnt == DIV_C - 7'h01);
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      div_cnt <= 7'h00;
    end else if (!busy || fall) begin
      div_cnt <= 7'h00;
    end else begin
      div_cnt <= div_cnt + 7'h01;
    end
  end
  // Management clock low at rest, rises mid bit
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      mgmt_clock_out <= 1'b0;
    end else if (rise) begin
      mgmt_clock_out <= 1'b1;
    end else if (fall || !busy) begin
      mgmt_clock_out <= 1'b0;
    end
  end
  // Frame assembly and serial shift
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      busy <= 1'b0;
      reading <= 1'b0;
      bit_idx <= 7'h00;
      shifter <= 64'h0000_0000_0000_0000;
      mdio_out <= 1'b1;
      mdio_oe_out <= 1'b0;
      fr.done <= 1'b0;
    end else begin
      fr.done <= 1'b0;
      if (!busy && fr.start) begin
        busy <= 1'b1;
        reading <= (fr.opcode == OP_READ);
        bit_idx <= 7'h00;
        shifter <= {{PREAMBLE_BITS{1'b1}}, START_PAT, fr.opcode, fr.port, fr.device,
          TA_DRIVEN, fr.payload};
        mdio_out <= 1'b1;
        mdio_oe_out <= 1'b1;
      end else if (fall) begin
        if (bit_idx == 7'(FRAME_BITS - 1)) begin
          busy <= 1'b0;
          mdio_oe_out <= 1'b0;
          mdio_out <= 1'b1;
          fr.done <= 1'b1;
        end else begin
          bit_idx <= bit_idx + 7'h01;
          shifter <= {shifter[62:0], 1'b0};
          mdio_out <= shifter[62];
          // Release from first turnaround bit of a read onward
          mdio_oe_out <= !(reading && (bit_idx + 7'h01 >= 7'(TA_FIRST_BIT)));
        end
      end
    end
  end
  // Sample read data on rising edges of the data field
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      capture <= 16'h0000;
    end else if (rise && reading && bit_idx >= 7'(DATA_FIRST_BIT)) begin
      capture <= {capture[14:0], mdio_in};
    end
  end
  assign fr.result = capture;
endmodule

// >>> verilog/mgmt_master.sv
// Purpose: Memory-mapped slave that runs indirect-access management frames to a PHY
// Assumes: Single clock; slave data 32 bits; unmapped reads return zero after one wait cycle
// Notes: Each access at ACCESS_IDX sends an address frame then a write or read frame
//
// The implementer's own choices: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
module mgmt_master #(
  parameter int DIVIDER = mgmt_pkg::DIVIDER_DEFAULT
) (
  input wire logic clock_in,
  input wire logic arst_n_in,
  input wire logic [mgmt_pkg::ADDR_W-1:0] address_in,
  input wire logic read_in,
  input wire logic write_in,
  input wire logic [31:0] writedata_in,
  output logic [31:0] readdata_out,
  output logic waitrequest_out,
  output logic mgmt_clock_out,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe_out
);
  import mgmt_pkg::*;
  typedef enum {IDLE, ADDR_FRAME, DATA_FRAME, FINISH} seq_t;

  // Divider range and management clock ceiling
  if (DIVIDER < DIVIDER_MIN || DIVIDER > DIVIDER_MAX || DIVIDER < DIVIDER_LEAST) begin : g_bad
    $error("Divider out of range");
  end

  frame_if fr ();
  seq_t state;
  logic [31:0] addressing;
  logic [15:0] write_value;
  logic is_read;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] idx);
    return a == idx;
  endfunction

  frame_engine #(.DIVIDER(DIVIDER)) engine_u (
    .clock_in(clock_in),
    .arst_n_in(arst_n_in),
    .fr(fr.engine),
    .mdio_in(mdio_in),
    .mgmt_clock_out(mgmt_clock_out),
    .mdio_out(mdio_out),
    .mdio_oe_out(mdio_oe_out)
  );

  // Addressing register, reserved bits forced to zero
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      addressing <= ADDRESSING_RESET;
    end else if (write_in && hit(address_in, ADDRESSING_IDX) && waitrequest_out) begin
      addressing <= writedata_in & ADDRESSING_MASK;
    end
  end

  // Transaction sequencer
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state <= IDLE;
      is_read <= 1'b0;
      write_value <= 16'h0000;
      fr.start <= 1'b0;
      fr.opcode <= OP_ADDRESS;
      fr.port <= 5'h00;
      fr.device <= 5'h00;
      fr.payload <= 16'h0000;
    end else begin
      fr.start <= 1'b0;
      case (state)
        IDLE: begin
          if ((read_in || write_in) && hit(address_in, ACCESS_IDX) && waitrequest_out) begin
            is_read <= read_in;
            write_value <= writedata_in[15:0];
            fr.start <= 1'b1;
            fr.opcode <= OP_ADDRESS;
            fr.port <= addressing[PORT_LSB +: 5];
            fr.device <= addressing[DEV_LSB +: 5];
            fr.payload <= addressing[REG_LSB +: 16];
            state <= ADDR_FRAME;
          end
        end
        ADDR_FRAME: begin
          if (fr.done) begin
            fr.start <= 1'b1;
            fr.opcode <= is_read ? OP_READ : OP_WRITE;
            fr.payload <= is_read ? 16'h0000 : write_value;
            state <= DATA_FRAME;
          end
        end
        DATA_FRAME: begin
          if (fr.done) begin
            state <= FINISH;
          end
        end
        FINISH: begin
          state <= IDLE;
        end
        default: begin
          state <= IDLE;
        end
      endcase
    end
  end

  // Slave answer: access held until its frames finish
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      waitrequest_out <= 1'b1;
      readdata_out <= 32'h0000_0000;
    end else if (!waitrequest_out) begin
      waitrequest_out <= 1'b1;
    end else if (state == FINISH) begin
      waitrequest_out <= 1'b0;
      readdata_out <= is_read ? {16'h0000, fr.result} : UNMAPPED_READ;
    end else if (state == IDLE && (read_in || write_in) && !hit(address_in, ACCESS_IDX)) begin
      waitrequest_out <= 1'b0;
      readdata_out <= hit(address_in, ADDRESSING_IDX) ? addressing : UNMAPPED_READ;
    end
  end
endmodule

// >>> testbench/mgmt_master_asserts.sv
// Purpose: Port checks for the management master
// Assumes: Frames always run 64 bits
// Notes: Bit index counts management clock rises
`timescale 1ns/1ps
module mgmt_master_asserts #(
  parameter int DIVIDER = 32
) (
  input wire logic clock_in,
  input wire logic arst_n_in,
  input wire logic [mgmt_pkg::ADDR_W-1:0] address_in,
  input wire logic read_in,
  input wire logic write_in,
  input wire logic waitrequest_out,
  input wire logic mgmt_clock_out,
  input wire logic mdio_in,
  input wire logic mdio_out,
  input wire logic mdio_oe_out
);
  import mgmt_pkg::*;
  logic last, rise, acc;
  logic [5:0] n;
  logic [15:0] sh;
  logic [7:0] edges;
  assign rise = mgmt_clock_out && !last;
  assign acc = (read_in || write_in) && address_in == ACCESS_IDX;
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      {last, n, sh, edges} <= '0;
    end else begin
      last <= mgmt_clock_out;
      n <= n + 6'(rise);
      sh <= rise ? {sh[14:0], mdio_in} : sh;
      edges <= acc ? edges + 8'(rise) : 8'h00;
    end
  end
  default clocking @(posedge clock_in); endclocking
  default disable iff (!arst_n_in);
  ack_pulse_a: assert property ($fell(waitrequest_out) |=> waitrequest_out)
    else $error("ack too long");
  two_frames_a: assert property (acc && !waitrequest_out |-> edges == 8'h80)
    else $error("frame count");
  preamble_a: assert property (rise && n < 6'h20 |-> mdio_oe_out && mdio_out)
    else $error("preamble");
  start_a: assert property (rise && n[5:1] == 5'h10 |-> mdio_oe_out && !mdio_out)
    else $error("start");
  op_legal_a: assert property (rise && n == 6'h24 |-> sh[1:0] != 2'h2)
    else $error("opcode 10 sent");
  ta_float_a: assert property (rise && n == 6'h2E && sh[11:10] == OP_READ
    |-> !mdio_oe_out) else $error("turnaround driven");
  ta_one_a: assert property (rise && n == 6'h2E && sh[11:10] != OP_READ
    |-> mdio_oe_out && mdio_out) else $error("turnaround one");
  ta_zero_a: assert property (rise && n == 6'h2F && sh[12:11] != OP_READ
    |-> mdio_oe_out && !mdio_out) else $error("turnaround zero");
  idle_off_a: assert property (!(read_in || write_in)
    |-> !mdio_oe_out && !mgmt_clock_out) else $error("driving while idle");
  cover property (acc && read_in && !waitrequest_out);
  cover property (acc && write_in && !waitrequest_out);
  cover property (rise && n == 6'h2E && sh[11:10] == OP_READ);
endmodule

// >>> testbench/phy_model.sv
// Purpose: Behavioural PHY management port
// Assumes: Frames always run 64 bits
// Notes: Read data mixes stored register address with port and device
`timescale 1ns/1ps
module phy_model (
  input wire logic mgmt_clock_in,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe_out,
  output logic [41:0] last_write_out
);
  logic [63:0] sh = 64'h0000_0000_0000_0000;
  logic [15:0] regad = 16'h0000, rd = 16'h0000;
  logic rdop = 1'b0;
  int n = 0;
  initial begin
    mdio_out = 1'b1;
    mdio_oe_out = 1'b0;
  end
  always @(posedge mgmt_clock_in) begin
    sh = {sh[62:0], mdio_in};
    n = (n + 1) % 64;
    if (n == 0 && sh[29:28] == 2'h0) regad = sh[15:0];
    if (n == 0 && sh[29:28] == 2'h1) last_write_out = {sh[27:18], regad, sh[15:0]};
  end
  always @(negedge mgmt_clock_in) begin
    if (n == 47) begin
      rdop = sh[12:11] == 2'h3;
      rd = regad ^ {sh[10:1], 6'h2A};
    end
    if (rdop && n >= 47) begin
      mdio_oe_out = 1'b1;
      mdio_out = n == 47 ? 1'b0 : rd[63 - n];
    end else if (mdio_oe_out) begin
      mdio_oe_out = 1'b0;
      mdio_out = ~mdio_out;
    end
  end
endmodule

// >>> testbench/mgmt_master_test.sv
// Purpose: Random and corner accesses to the management master
// Assumes: DIVIDER of 10 keeps frames short
// Notes: Line level resolves both drivers and the pull-up
`timescale 1ns/1ps
module mgmt_master_test;
  import mgmt_pkg::*;
  logic clock_in = 1'b0, arst_n_in = 1'b0, read_in = 1'b0, write_in = 1'b0;
  logic [ADDR_W-1:0] address_in = 6'h00;
  logic [31:0] writedata_in = 32'h0000_0000, readdata_out, q;
  logic waitrequest_out, mgmt_clock_out, mdio_in, mdio_out, mdio_oe_out, phy_d, phy_oe;
  logic [41:0] wr;
  logic [15:0] ra, wd;
  logic [4:0] pa, da;
  int err_count = 0;
  int tests_run = 0;
  always #20 clock_in = ~clock_in;
  assign mdio_in = mdio_oe_out ? mdio_out : (phy_oe ? phy_d : 1'b1);
  mgmt_master #(.DIVIDER(10)) mgmt_master_i (.clock_in, .arst_n_in, .address_in, .read_in,
    .write_in, .writedata_in, .readdata_out, .waitrequest_out, .mgmt_clock_out, .mdio_in,
    .mdio_out, .mdio_oe_out);
  phy_model phy_model_i (.mgmt_clock_in(mgmt_clock_out), .mdio_in, .mdio_out(phy_d),
    .mdio_oe_out(phy_oe), .last_write_out(wr));
  function automatic logic [15:0] exp_read(logic [15:0] r, logic [4:0] p, logic [4:0] d);
    return r ^ {p, d, 6'h2A};
  endfunction
  task automatic chk(input string name, input logic [41:0] exp, input logic [41:0] got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic bus(input logic wr_en, input logic [5:0] a, input logic [31:0] d);
    @(posedge clock_in);
    {address_in, writedata_in, write_in, read_in} <= {a, d, wr_en, !wr_en};
    do begin
      @(posedge clock_in);
    end while (waitrequest_out !== 1'b0);
    q = readdata_out;
    {write_in, read_in} <= 2'h0;
  endtask
  task automatic test_done();
    $display("Checks %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge clock_in);
    err_count++;
    test_done();
  end
  initial begin
    void'($urandom(68));
    repeat (5) @(posedge clock_in);
    arst_n_in <= 1'b1;
    bus(1'b0, 6'h05, 32'h0000_0000);
    chk("unmapped", 42'(UNMAPPED_READ), 42'(q));
    bus(1'b1, ADDRESSING_IDX, 32'hFFFF_FFFF);
    bus(1'b1, 6'h01, 32'h0000_0000);
    bus(1'b0, ADDRESSING_IDX, 32'h0000_0000);
    chk("addressing", 42'h0_FFFF_1F1F, 42'(q));
    for (int i = 0; i < 6; i++) begin
      {ra, pa, da, wd} = i == 0 ? {16'hFFFF, 5'h1F, 5'h00, 16'h8001} : 42'({$urandom, $urandom});
      bus(1'b1, ADDRESSING_IDX, {ra, 3'h0, pa, 3'h0, da});
      bus(1'b1, ACCESS_IDX, {16'h0000, wd});
      chk("write frame", {pa, da, ra, wd}, wr);
      bus(1'b0, ACCESS_IDX, 32'h0000_0000);
      chk("read data", 42'(exp_read(ra, pa, da)), 42'(q));
    end
    arst_n_in <= 1'b0;
    repeat (2) @(posedge clock_in);
    arst_n_in <= 1'b1;
    bus(1'b0, ADDRESSING_IDX, 32'h0000_0000);
    chk("addressing reset", 42'(ADDRESSING_RESET), 42'(q));
    test_done();
  end
endmodule
bind mgmt_master mgmt_master_asserts #(.DIVIDER(DIVIDER)) mgmt_master_asserts_i (.clock_in,
  .arst_n_in, .address_in, .read_in, .write_in, .waitrequest_out, .mgmt_clock_out, .mdio_in,
  .mdio_out, .mdio_oe_out);
